// ===== acb_pkg.sv
// Purpose: shared constants for the amplifier control register bank
// Assumes: 8-bit registers reached over a two-wire control port
// Notes: offsets are register indices on the control port
package acb_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CHIP_IDENTITY = 8'h00;
  localparam logic [7:0] OFS_POWER_CLIP_HIGH = 8'h01;
  localparam logic [7:0] OFS_DIGITAL_PATH = 8'h02;
  localparam logic [7:0] OFS_VOLUME_FADE_MUTE = 8'h03;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_POWER_CLIP_HIGH = 8'hfd;
  localparam logic [7:0] RST_DIGITAL_PATH = 8'h14;
  localparam logic [7:0] RST_VOLUME_FADE_MUTE = 8'h80;

  // ----------------------------------------------------------------
  // writable-bit masks, reserved bits read zero
  // ----------------------------------------------------------------
  localparam logic [7:0] MSK_POWER_CLIP_HIGH = 8'hff;
  localparam logic [7:0] MSK_DIGITAL_PATH = 8'hbf;
  localparam logic [7:0] MSK_VOLUME_FADE_MUTE = 8'h83;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CLIP_HI_MSB = 7;
  localparam int CLIP_HI_LSB = 2;
  localparam int BIT_SLEEP = 1;
  localparam int BIT_SHUTDOWN_N = 0;
  localparam int BIT_HIGHPASS_SKIP = 7;
  localparam int BOOST_MSB = 5;
  localparam int BOOST_LSB = 4;
  localparam int BIT_RATE_RANGE = 3;
  localparam int FMT_MSB = 2;
  localparam int BIT_FADE = 7;
  localparam int BIT_MUTE_RIGHT = 1;
  localparam int BIT_MUTE_LEFT = 0;

  // ----------------------------------------------------------------
  // input format codes
  // ----------------------------------------------------------------
  localparam logic [2:0] FMT_RJ24 = 3'h0;
  localparam logic [2:0] FMT_RJ20 = 3'h1;
  localparam logic [2:0] FMT_RJ18 = 3'h2;
  localparam logic [2:0] FMT_RJ16 = 3'h3;
  localparam logic [2:0] FMT_I2S = 3'h4;
  localparam logic [2:0] FMT_LEFT = 3'h5;

  // ----------------------------------------------------------------
  // pin synchroniser depth
  // ----------------------------------------------------------------
  localparam int SYNC_STAGES = 3;

  typedef enum logic [2:0] {
    ST_IDLE, ST_DEVADR, ST_ACK, ST_PTR, ST_WDATA, ST_RDATA, ST_MACK
  } acb_state_t;

endpackage : acb_pkg

// ===== acb_pin_sync.sv
// Purpose: three-flop synchroniser with agreement filter for one pin
// Assumes: pin is asynchronous to clock
// Notes: output moves only when the second and third flops agree
`timescale 1ns/1ps
module acb_pin_sync #(
  parameter logic IDLE_LEVEL = 1'b1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic pin,
  output logic level
);
  import acb_pkg::*;

  logic [SYNC_STAGES-1:0] stage_r;

  // first stage feeds only the second
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage_r <= {SYNC_STAGES{IDLE_LEVEL}};
    end else begin
      stage_r <= {stage_r[SYNC_STAGES-2:0], pin};
    end
  end

  wire agree = (stage_r[1] == stage_r[2]);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      level <= IDLE_LEVEL;
    end else if (agree) begin
      level <= stage_r[2];
    end
  end

endmodule : acb_pin_sync

// ===== acb_bank.sv
// Purpose: control register bank with two-wire control port slave
// Assumes: host is the control master; scl never driven by this block
// Notes: pointer auto-increments per data byte, reads and writes alike
`timescale 1ns/1ps
module acb_bank #(
  parameter logic [6:0] DEV_ADDR = 7'h2a,
  parameter logic [7:0] CHIP_ID = 8'h5a // arbitrary identity value
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [7:0] clip_mid_bits,
  input wire logic [5:0] clip_low_bits,
  output logic [19:0] clip_threshold,
  output logic amp_sleep,
  output logic amp_shutdown_n,
  output logic power_stage_en,
  output logic low_volt_en,
  output logic highpass_skip,
  output logic [1:0] boost_code,
  output logic [4:0] boost_db,
  output logic rate_range_select,
  output logic [2:0] input_format,
  output logic fmt_right_just,
  output logic fmt_i2s,
  output logic fmt_left_just,
  output logic [4:0] rj_word_bits,
  output logic fade_enable,
  output logic mute_right,
  output logic mute_left
);
  import acb_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers and bus conditions
  // ----------------------------------------------------------------
  logic scl_s, sda_s, scl_q_r, sda_q_r;

  acb_pin_sync #(.IDLE_LEVEL(1'b1)) u_scl_sync (
    .clock(clock), .rst(rst), .pin(scl), .level(scl_s));
  acb_pin_sync #(.IDLE_LEVEL(1'b1)) u_sda_sync (
    .clock(clock), .rst(rst), .pin(sda_in), .level(sda_s));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_q_r;
  wire scl_fall = ~scl_s & scl_q_r;
  wire bus_start = scl_s & scl_q_r & sda_q_r & ~sda_s;
  wire bus_stop = scl_s & scl_q_r & ~sda_q_r & sda_s;

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] power_r, digital_r, volume_r;
  logic [7:0] ptr_r, shift_r, tx_r;
  logic [2:0] bit_cnt_r;
  logic byte_rdy_r, rw_r, oe_r, wr_pulse_r;
  logic [7:0] wr_ptr_r, wr_data_r;
  acb_state_t state_r, after_ack_r;

  function automatic logic [7:0] read_byte(input logic [7:0] a,
      input logic [7:0] p, input logic [7:0] d, input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      OFS_CHIP_IDENTITY: r = CHIP_ID;
      OFS_POWER_CLIP_HIGH: r = p & MSK_POWER_CLIP_HIGH;
      OFS_DIGITAL_PATH: r = d & MSK_DIGITAL_PATH;
      OFS_VOLUME_FADE_MUTE: r = v & MSK_VOLUME_FADE_MUTE;
      default: r = 8'h00;
    endcase
    return r;
  endfunction : read_byte

  wire [7:0] rd_now = read_byte(ptr_r, power_r, digital_r, volume_r);
  wire addr_hit = (shift_r[7:1] == DEV_ADDR);
  wire sel_power = wr_pulse_r & (wr_ptr_r == OFS_POWER_CLIP_HIGH);
  wire sel_digital = wr_pulse_r & (wr_ptr_r == OFS_DIGITAL_PATH);
  wire sel_volume = wr_pulse_r & (wr_ptr_r == OFS_VOLUME_FADE_MUTE);

  // identity has no storage, so writes to it fall away
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      power_r <= RST_POWER_CLIP_HIGH;
      digital_r <= RST_DIGITAL_PATH;
      volume_r <= RST_VOLUME_FADE_MUTE;
    end else begin
      if (sel_power) power_r <= wr_data_r & MSK_POWER_CLIP_HIGH;
      // reserved bit 6 is masked so it cannot leave zero
      if (sel_digital) digital_r <= wr_data_r & MSK_DIGITAL_PATH;
      if (sel_volume) volume_r <= wr_data_r & MSK_VOLUME_FADE_MUTE;
    end
  end

  // ----------------------------------------------------------------
  // control port state machine
  // ----------------------------------------------------------------
  // start and stop take priority over any bit activity
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      after_ack_r <= ST_IDLE;
      ptr_r <= 8'h00;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      bit_cnt_r <= 3'h0;
      byte_rdy_r <= 1'b0;
      rw_r <= 1'b0;
      oe_r <= 1'b0;
      wr_pulse_r <= 1'b0;
      wr_ptr_r <= 8'h00;
      wr_data_r <= 8'h00;
    end else begin
      wr_pulse_r <= 1'b0;
      if (bus_start) begin
        state_r <= ST_DEVADR;
        bit_cnt_r <= 3'h0;
        byte_rdy_r <= 1'b0;
        oe_r <= 1'b0;
      end else if (bus_stop) begin
        state_r <= ST_IDLE;
        oe_r <= 1'b0;
      end else begin
        case (state_r)
          ST_DEVADR, ST_PTR, ST_WDATA: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda_s};
              bit_cnt_r <= bit_cnt_r + 3'h1;
              byte_rdy_r <= (bit_cnt_r == 3'h7);
            end else if (scl_fall && byte_rdy_r) begin
              byte_rdy_r <= 1'b0;
              oe_r <= 1'b1;
              state_r <= ST_ACK;
              if (state_r == ST_DEVADR) begin
                rw_r <= shift_r[0];
                after_ack_r <= shift_r[0] ? ST_RDATA : ST_PTR;
                if (!addr_hit) begin
                  oe_r <= 1'b0;
                  state_r <= ST_IDLE;
                end
              end else if (state_r == ST_PTR) begin
                ptr_r <= shift_r;
                after_ack_r <= ST_WDATA;
              end else begin
                wr_pulse_r <= 1'b1;
                wr_ptr_r <= ptr_r;
                wr_data_r <= shift_r;
                ptr_r <= ptr_r + 8'h01;
                after_ack_r <= ST_WDATA;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bit_cnt_r <= 3'h0;
              state_r <= after_ack_r;
              oe_r <= 1'b0;
              if (after_ack_r == ST_RDATA) begin
                tx_r <= rd_now;
                oe_r <= ~rd_now[7];
                ptr_r <= ptr_r + 8'h01;
              end
            end
          end
          ST_RDATA: begin
            if (scl_rise) begin
              bit_cnt_r <= bit_cnt_r + 3'h1;
              byte_rdy_r <= (bit_cnt_r == 3'h7);
            end else if (scl_fall) begin
              if (byte_rdy_r) begin
                byte_rdy_r <= 1'b0;
                oe_r <= 1'b0;
                state_r <= ST_MACK;
              end else begin
                tx_r <= {tx_r[6:0], 1'b0};
                oe_r <= ~tx_r[6];
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              byte_rdy_r <= ~sda_s;
              if (sda_s) state_r <= ST_IDLE;
            end else if (scl_fall && byte_rdy_r) begin
              byte_rdy_r <= 1'b0;
              bit_cnt_r <= 3'h0;
              tx_r <= rd_now;
              oe_r <= ~rd_now[7];
              ptr_r <= ptr_r + 8'h01;
              state_r <= ST_RDATA;
            end
          end
          ST_IDLE: begin
            oe_r <= 1'b0;
          end
          default: begin
            state_r <= ST_IDLE;
            oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = oe_r;

  // ----------------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------------
  wire [2:0] fmt_w = digital_r[FMT_MSB:0];
  wire [1:0] boost_w = digital_r[BOOST_MSB:BOOST_LSB];
  wire rj_w = (fmt_w == FMT_RJ24) | (fmt_w == FMT_RJ20) |
              (fmt_w == FMT_RJ18) | (fmt_w == FMT_RJ16);
  wire [4:0] rj_bits_w = (fmt_w == FMT_RJ24) ? 5'h18 :
                         (fmt_w == FMT_RJ20) ? 5'h14 :
                         (fmt_w == FMT_RJ18) ? 5'h12 :
                         (fmt_w == FMT_RJ16) ? 5'h10 : 5'h00;
  // codes above left-justified select no framing at all
  wire [4:0] boost_db_w = {boost_w, 1'b0} + {1'b0, boost_w, 2'b00};

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clip_threshold <= 20'h00000;
    end else begin
      clip_threshold <= {power_r[CLIP_HI_MSB:CLIP_HI_LSB],
                         clip_mid_bits, clip_low_bits};
    end
  end

  assign amp_sleep = power_r[BIT_SLEEP];
  assign amp_shutdown_n = power_r[BIT_SHUTDOWN_N];
  // sleep keeps the low-voltage side up for a quick resume
  assign power_stage_en = power_r[BIT_SHUTDOWN_N] & ~power_r[BIT_SLEEP];
  assign low_volt_en = power_r[BIT_SHUTDOWN_N];
  assign highpass_skip = digital_r[BIT_HIGHPASS_SKIP];
  assign boost_code = boost_w;
  assign boost_db = boost_db_w;
  assign rate_range_select = digital_r[BIT_RATE_RANGE];
  assign input_format = fmt_w;
  assign fmt_right_just = rj_w;
  assign fmt_i2s = (fmt_w == FMT_I2S);
  assign fmt_left_just = (fmt_w == FMT_LEFT);
  assign rj_word_bits = rj_bits_w;
  assign fade_enable = volume_r[BIT_FADE];
  assign mute_right = volume_r[BIT_MUTE_RIGHT];
  assign mute_left = volume_r[BIT_MUTE_LEFT];

endmodule : acb_bank

// ===== acb_host_model.sv
// Purpose: behavioural control-port master for the register bank
// Assumes: sda is pulled up, each party only pulls it low
// Notes: every change lands 1 ns after a clock rise
`timescale 1ns/1ps
module acb_host #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input wire logic clock,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // phases stay >= 8 clocks so the pin synchronisers keep up
  localparam int HALF = 10;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic bit_io(input logic b, output logic smp);
    sda_low = !b;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    smp = sda;
    scl = 1'b0;
    // let the scl fall be seen before sda moves
    tick(3);
  endtask : bit_io
  task automatic start;
    sda_low = 1'b0;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_low = 1'b1;
    tick(HALF);
    scl = 1'b0;
    tick(3);
  endtask : start
  task automatic stop;
    sda_low = 1'b1;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_low = 1'b0;
    tick(HALF);
  endtask : stop
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
  endtask : byte_io
  task automatic send(input logic [7:0] b, output logic nak);
    logic [7:0] q;
    byte_io(b, q);
    bit_io(1'b1, nak);
  endtask : send
  // callers keep digital bit 6 clear and format codes legal
  task automatic wr(input logic [6:0] a, input logic [7:0] p,
                    input logic [7:0] d, output logic nak);
    logic n;
    start();
    send({a, 1'b0}, nak);
    send(p, n);
    send(d, n);
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic n;
    start();
    send({ADDR, 1'b0}, n);
    send(p, n);
    start();
    send({ADDR, 1'b1}, n);
    byte_io(8'hff, d);
    // nack ends the read
    bit_io(1'b1, n);
    stop();
  endtask : rd
endmodule : acb_host

// ===== acb_bank_props.sv
// Purpose: port-level checks for the amplifier control register bank
// Assumes: single clock, async active-high reset
// Notes: decoded outputs are checked against their register fields
`timescale 1ns/1ps
module acb_bank_props (
  input wire logic clock,
  input wire logic rst,
  input wire logic sda_oe,
  input wire logic [7:0] clip_mid_bits,
  input wire logic [5:0] clip_low_bits,
  input wire logic [19:0] clip_threshold,
  input wire logic amp_sleep,
  input wire logic amp_shutdown_n,
  input wire logic power_stage_en,
  input wire logic low_volt_en,
  input wire logic [1:0] boost_code,
  input wire logic [4:0] boost_db,
  input wire logic [2:0] input_format,
  input wire logic fmt_right_just,
  input wire logic fmt_i2s,
  input wire logic fmt_left_just,
  input wire logic [4:0] rj_word_bits,
  input wire logic fade_enable,
  input wire logic mute_right,
  input wire logic mute_left
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  chk_power_stage: assert property (
    power_stage_en == (amp_shutdown_n && !amp_sleep)) else $error("stage");
  chk_low_volt: assert property (
    low_volt_en == amp_shutdown_n) else $error("low volt enable");
  chk_boost_gain: assert property (
    boost_db == {3'h0, boost_code} * 5'h06) else $error("boost gain");
  chk_rj_decode: assert property (
    fmt_right_just == !input_format[2]) else $error("rj decode");
  chk_rj_width: assert property (
    fmt_right_just |-> rj_word_bits == (input_format == 3'h0 ? 5'h18 :
      input_format == 3'h1 ? 5'h14 : input_format == 3'h2 ? 5'h12 : 5'h10))
    else $error("rj width");
  chk_fmt_framing: assert property (
    fmt_i2s == (input_format == 3'h4) && fmt_left_just == (input_format == 3'h5))
    else $error("framing decode");
  chk_clip_concat: assert property (
    !$past(rst) |-> clip_threshold[13:0] == $past({clip_mid_bits, clip_low_bits}))
    else $error("clip concat");
  chk_reset_fields: assert property (disable iff (1'b0) rst |->
    amp_shutdown_n && !amp_sleep && fade_enable && !mute_left && !mute_right
    && boost_code == 2'h1 && fmt_i2s) else $error("reset fields");
  cover property (amp_sleep);
  cover property (fmt_left_just);
  cover property (mute_right && mute_left);
  cover property ($rose(sda_oe));
endmodule : acb_bank_props
bind acb_bank acb_bank_props i_props (.clock(clock), .rst(rst), .sda_oe(sda_oe),
  .clip_mid_bits(clip_mid_bits), .clip_low_bits(clip_low_bits),
  .clip_threshold(clip_threshold), .amp_sleep(amp_sleep),
  .amp_shutdown_n(amp_shutdown_n), .power_stage_en(power_stage_en),
  .low_volt_en(low_volt_en), .boost_code(boost_code), .boost_db(boost_db),
  .input_format(input_format), .fmt_right_just(fmt_right_just),
  .fmt_i2s(fmt_i2s), .fmt_left_just(fmt_left_just),
  .rj_word_bits(rj_word_bits), .fade_enable(fade_enable),
  .mute_right(mute_right), .mute_left(mute_left));

// ===== testbench.sv
// Purpose: self-checking bench for the amplifier control register bank
// Assumes: host model drives the control port, sda pulled up here
// Notes: rows are {pointer, write, readback, port view}
`timescale 1ns/1ps
module testbench;
  import acb_pkg::*;
  localparam logic [6:0] ADDR = 7'h2a;
  localparam logic [7:0] ID = 8'h66; // arbitrary identity value
  localparam logic [7:0] RV [4] = '{ID, 8'hfd, 8'h14, 8'h80};
  localparam logic [43:0] ROWS [12] = '{44'h01_aa_aa_002a2,
    44'h01_01_01_0000d, 44'h02_8d_8d_20d01, 44'h02_30_30_120c4,
    44'h02_21_21_0c1a4, 44'h02_12_12_06294, 44'h02_03_03_00384,
    44'h02_80_80_200c4, 44'h02_14_14_06402, 44'h03_ff_83_00007,
    44'h03_02_02_00002, 44'h00_33_66_00000};
  logic clock, rst, scl, sda, host_low, sda_out, sda_oe, nak;
  logic amp_sleep, amp_shutdown_n, power_stage_en, low_volt_en;
  logic highpass_skip, rate_range_select, fmt_right_just, fmt_i2s;
  logic fmt_left_just, fade_enable, mute_right, mute_left;
  logic [7:0] clip_mid_bits, d;
  logic [5:0] clip_low_bits;
  logic [19:0] clip_threshold;
  logic [1:0] boost_code;
  logic [4:0] boost_db, rj_word_bits;
  logic [2:0] input_format;
  int cmp_count = 0;
  int n_mismatch = 0;
  int cycles = 0;
  assign sda = !(host_low || (sda_oe && !sda_out));
  acb_bank #(.DEV_ADDR(ADDR), .CHIP_ID(ID)) i_dut (.clock(clock), .rst(rst),
    .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .clip_mid_bits(clip_mid_bits), .clip_low_bits(clip_low_bits),
    .clip_threshold(clip_threshold), .amp_sleep(amp_sleep),
    .amp_shutdown_n(amp_shutdown_n), .power_stage_en(power_stage_en),
    .low_volt_en(low_volt_en), .highpass_skip(highpass_skip),
    .boost_code(boost_code), .boost_db(boost_db),
    .rate_range_select(rate_range_select), .input_format(input_format),
    .fmt_right_just(fmt_right_just), .fmt_i2s(fmt_i2s),
    .fmt_left_just(fmt_left_just), .rj_word_bits(rj_word_bits),
    .fade_enable(fade_enable), .mute_right(mute_right), .mute_left(mute_left));
  acb_host #(.ADDR(ADDR)) i_host (.clock(clock), .sda(sda), .scl(scl),
    .sda_low(host_low));
  function automatic logic [19:0] pv(input logic [7:0] p);
    case (p)
      8'h01: pv = {10'h0, clip_threshold[19:14], power_stage_en, low_volt_en,
                   amp_sleep, amp_shutdown_n};
      8'h02: pv = {2'h0, highpass_skip, boost_db, rate_range_select,
                   input_format, rj_word_bits, fmt_right_just, fmt_i2s,
                   fmt_left_just};
      8'h03: pv = {17'h0, fade_enable, mute_right, mute_left};
      default: pv = 20'h0;
    endcase
  endfunction : pv
  task automatic cmp(input string nm, input logic [19:0] e,
                     input logic [19:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // ceiling is over twice the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    // raise reset as a real edge before the first clock, not at time zero
    rst = 1'b0;
    #1;
    rst = 1'b1;
    clip_mid_bits = 8'h3c;
    clip_low_bits = 6'h15;
    i_host.tick(6);
    rst = 1'b0;
    i_host.tick(4);
    foreach (ROWS[i]) begin
      i_host.wr(ADDR, ROWS[i][43:36], ROWS[i][35:28], nak);
      i_host.rd(ROWS[i][43:36], d);
      cmp("readback", {12'h0, ROWS[i][27:20]}, {12'h0, d});
      cmp("ports", ROWS[i][19:0], pv(ROWS[i][43:36]));
      $display("row %0d done", i);
    end
    i_host.wr(ADDR + 7'h1, 8'h01, 8'h00, nak);
    i_host.rd(8'h01, d);
    cmp("foreign address", 20'h1, {19'h0, nak});
    cmp("power kept", 20'h01, {12'h0, d});
    i_host.rd(8'h07, d);
    cmp("unmapped", 20'h0, {12'h0, d});
    $display("address test done");
    rst = 1'b1;
    i_host.tick(2);
    rst = 1'b0;
    i_host.tick(4);
    for (int p = 0; p < 4; p++) begin
      i_host.rd(8'(p), d);
      cmp("reset value", {12'h0, RV[p]}, {12'h0, d});
    end
    clip_mid_bits = 8'ha5;
    clip_low_bits = 6'h2c;
    i_host.tick(2);
    cmp("clip threshold", 20'hfe96c, clip_threshold);
    $display("reset test done");
    give_verdict();
  end
endmodule : testbench
